// File: dcab_top.sv
// Four channel DMA arbiter with bus mode and address mode sequencing.
// Overview of operation
// - Pick one channel among simultaneous requests
// - Fixed mode offers three constant orders
// - Round robin: finished channel becomes lowest
// - Round robin order after reset 0,1,2,3
// - Idle round robin returns to 0,1,2,3
// - Single address: one cycle, strobe plus address
// - Single address only from external request
// - Dual address: read cycle then write cycle
// - Bus mode bit: 1 burst, 0 cycle steal
// - Cycle steal releases bus after each unit
// - Burst keeps bus until end condition
// - Burst release follows burst priority setting
// - Level burst: request high releases bus
// - Normal mode: external requests channels 0,1
// - Transfer request mode: all channels external
// - Higher priority request preempts a burst
// - Fixed: preempted burst waits full completion
// - Round robin: channels alternate unit by unit
// - Edge burst holds bus; level burst yields
// - Sense bit: 0 low level, 1 falling edge
// - Transfer needs enables set, flags clear
//
// Added by the designer: the APB slave port and the register addresses.
module dcab_top
  import dcab_pkg::*;
#(
  parameter int CH = DCAB_CHANNELS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CH-1:0] external_transfer_request_n,
  input wire logic [CH-1:0] internal_request,
  input wire logic unit_done,
  input wire logic external_bus_request,
  input wire logic refresh_request,
  output logic bus_request,
  output logic cycle_valid,
  output dcab_cycle_t cycle_info,
  output logic [CH-1:0] transfer_acknowledge_strobe
);

  // Sequencer states, Gray coded along idle, read, write; write back to idle flips both bits.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b11
  } dcab_state_t;

  // Operation register fields and channel controls.
  logic [9:0] op_ff;
  dcab_chctl_t [CH-1:0] chctl_ff;
  // Current round robin order, two bits per slot, slot 0 highest.
  logic [7:0] rr_order_ff;
  // Held external requests and previous request level for edge sensing.
  logic [CH-1:0] held_req_ff;
  logic [CH-1:0] req_prev_ff;
  // Sequencer state and active channel.
  dcab_state_t state_ff;
  dcab_state_t nxt_state;
  logic [1:0] active_ff;
  // Registered outputs.
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic bus_request_ff;
  logic cycle_valid_ff;
  dcab_cycle_t cycle_info_ff;
  logic [CH-1:0] ack_ff;

  // Combinational helpers.
  logic [CH-1:0] eligible;
  logic [CH-1:0] pending;
  logic [7:0] cur_order;
  logic win_valid;
  logic [1:0] winner;
  logic unit_end;
  logic apb_access;
  logic dtr_mode;
  dcab_prio_t prio;
  // Decoded channel register index for the current APB address.
  logic [2:0] ctrl_sel;

  // Move a channel to the lowest slot, keeping the others in order.
  function automatic logic [7:0] rotate_out(input logic [7:0] ord, input logic [1:0] ch);
    logic [7:0] res;
    int k;
    res = 8'h00;
    k = 0;
    for (int s = 0; s < 4; s++) begin
      if (ord[2*s +: 2] != ch) begin
        res[2*k +: 2] = ord[2*s +: 2];
        k++;
      end
    end
    res[7:6] = ch;
    return res;
  endfunction

  // Byte address to channel control register index; 4 means not a channel.
  function automatic logic [2:0] ctrl_index(input logic [7:0] addr);
    case (addr)
      OFS_CTRL0: ctrl_index = 3'h0;
      OFS_CTRL1: ctrl_index = 3'h1;
      OFS_CTRL2: ctrl_index = 3'h2;
      OFS_CTRL3: ctrl_index = 3'h3;
      default: ctrl_index = 3'h4;
    endcase
  endfunction

  assign apb_access = psel && penable && !pready_ff;
  assign dtr_mode = op_ff[OP_DTR_MODE];
  // A function result cannot be part-selected, so the index is decoded once here.
  assign ctrl_sel = ctrl_index(paddr);
  assign prio = dcab_prio_t'(op_ff[OP_PRIO_HI:OP_PRIO_LO]);

  always_comb begin
    // Slot 0 sits in the low two bits and holds the highest channel.
    case (prio)
      DCAB_PRIO_FIX0123: cur_order = 8'he4;
      DCAB_PRIO_FIX0231: cur_order = 8'h78;
      DCAB_PRIO_FIX2013: cur_order = 8'hd2;
      DCAB_PRIO_RROBIN: cur_order = rr_order_ff;
      default: cur_order = 8'he4;
    endcase
  end

  // Gather which channels may be granted now.
  always_comb begin
    for (int c = 0; c < CH; c++) begin
      // external requests only channels 0 and 1 in normal mode
      // transfer request mode opens all channels
      if (chctl_ff[c].ext_req) begin
        pending[c] = held_req_ff[c] && (dtr_mode || c < 2);
      end else begin
        // single address needs an external request source
        pending[c] = internal_request[c] && chctl_ff[c].dual_addr;
      end
      // enables set and all flags clear
      eligible[c] = pending[c] && chctl_ff[c].enable && !chctl_ff[c].transfer_end &&
                    op_ff[OP_MASTER_ENABLE] && !op_ff[OP_NMI_FLAG] && !op_ff[OP_ADDR_ERR_FLAG];
    end
  end

  dcab_arbiter #(
    .CH(CH)
  ) u_arb (
    .request(eligible),
    .order(cur_order),
    .valid(win_valid),
    .winner(winner)
  );

  // A unit ends when the last bus cycle of that unit completes.
  assign unit_end = unit_done && ((state_ff == ST_WRITE) ||
                    (state_ff == ST_READ && !chctl_ff[active_ff].dual_addr));

  // request capture by level or falling edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      held_req_ff <= '0;
      req_prev_ff <= '1;
    end else begin
      req_prev_ff <= external_transfer_request_n;
      for (int c = 0; c < CH; c++) begin
        if (op_ff[OP_NMI_FLAG] || op_ff[OP_ADDR_ERR_FLAG] || chctl_ff[c].transfer_end) begin
          // Flags cancel a held request and ignore new ones.
          held_req_ff[c] <= 1'b0;
        end else if (chctl_ff[c].sense_edge) begin
          // A new falling edge wins over consumption in the same cycle.
          if (req_prev_ff[c] && !external_transfer_request_n[c]) begin
            held_req_ff[c] <= 1'b1;
          end else if (unit_end && active_ff == c[1:0] && !chctl_ff[c].burst) begin
            held_req_ff[c] <= 1'b0;
          end
        end else begin
          // Level sensing follows the pin directly.
          held_req_ff[c] <= !external_transfer_request_n[c];
        end
      end
    end
  end

  // Next state of the transfer sequencer.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (win_valid) begin
          nxt_state = ST_READ;
        end
      end
      ST_READ: begin
        if (unit_done) begin
          // dual address goes on to the write cycle
          // single address finishes in one cycle
          nxt_state = chctl_ff[active_ff].dual_addr ? ST_WRITE : ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (unit_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      active_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      // a higher channel wins the next unit at once
      if (state_ff == ST_IDLE && win_valid) begin
        active_ff <= winner;
      end
    end
  end

  // rotate the finished channel to lowest
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rr_order_ff <= RR_ORDER_RESET;
    end else if (unit_end) begin
      // alternation follows from per unit rotation
      rr_order_ff <= rotate_out(rr_order_ff, active_ff);
    end else if (state_ff == ST_IDLE && !win_valid) begin
      // no accepted request restores the default order
      rr_order_ff <= RR_ORDER_RESET;
    end
  end

  // Bus ownership toward the bus state controller.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_request_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && win_valid) begin
      bus_request_ff <= 1'b1;
    end else if (unit_end) begin
      // bus mode bit picks burst or cycle steal
      // cycle steal returns the bus after every unit
      // burst keeps the bus while any channel still requests
      // outside requests break in only when allowed
      // level burst releases once requests stop
      // edge burst holds the bus until its end
      // a preempted fixed-mode burst resumes after the winner ends
      bus_request_ff <= chctl_ff[active_ff].burst && (|eligible) &&
                        !((external_bus_request || refresh_request) && !op_ff[OP_BURST_PRIO]);
    end else if (state_ff == ST_IDLE && !win_valid) begin
      bus_request_ff <= 1'b0;
    end
  end

  // Cycle descriptor and acknowledge strobe outputs.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cycle_valid_ff <= 1'b0;
      cycle_info_ff <= '0;
      ack_ff <= '0;
    end else begin
      cycle_valid_ff <= (nxt_state != ST_IDLE);
      cycle_info_ff.channel <= (state_ff == ST_IDLE) ? winner : active_ff;
      cycle_info_ff.write_phase <= (nxt_state == ST_WRITE);
      cycle_info_ff.dual_addr <= chctl_ff[(state_ff == ST_IDLE) ? winner : active_ff].dual_addr;
      ack_ff <= '0;
      // strobe in the single address cycle
      // dual address strobe marks the read cycle of external requests
      if (nxt_state == ST_READ && state_ff == ST_IDLE &&
          chctl_ff[winner].ext_req) begin
        ack_ff[winner] <= 1'b1;
      end else if (nxt_state == ST_READ && state_ff == ST_READ && chctl_ff[active_ff].ext_req) begin
        ack_ff[active_ff] <= 1'b1;
      end
    end
  end

  // Register writes from APB; transfer end flags are set by software only.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      op_ff <= OP_RESET;
      for (int c = 0; c < CH; c++) begin
        chctl_ff[c] <= dcab_chctl_t'(CC_RESET);
      end
    end else if (apb_access && pwrite) begin
      if (paddr == OFS_OPERATION) begin
        op_ff <= pwdata[9:0];
      end else if (ctrl_sel != 3'h4) begin
        chctl_ff[ctrl_sel[1:0]] <= dcab_chctl_t'(pwdata[5:0]);
      end
    end
  end

  // APB slave: one wait state in each access phase, error on unmapped addresses.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= RD_UNMAPPED;
    end else begin
      pready_ff <= apb_access;
      pslverr_ff <= 1'b0;
      if (apb_access) begin
        prdata_ff <= RD_UNMAPPED;
        if (paddr == OFS_OPERATION) begin
          prdata_ff <= {22'h0, op_ff};
        end else if (paddr == OFS_STATUS) begin
          prdata_ff <= {16'h0, rr_order_ff, 1'b0, bus_request_ff, state_ff, held_req_ff};
        end else if (ctrl_sel != 3'h4) begin
          prdata_ff <= {26'h0, chctl_ff[ctrl_sel[1:0]]};
        end else begin
          pslverr_ff <= 1'b1;
        end
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign bus_request = bus_request_ff;
  assign cycle_valid = cycle_valid_ff;
  assign cycle_info = cycle_info_ff;
  assign transfer_acknowledge_strobe = ack_ff;

endmodule

// File: dcab_pkg.sv
// Package of constants, types and register map for the DMA channel arbiter.
package dcab_pkg;

  // Number of DMA channels handled by the arbiter.
  localparam int DCAB_CHANNELS = 4;

  // APB register byte addresses.
  localparam logic [7:0] OFS_OPERATION = 8'h00;
  localparam logic [7:0] OFS_CTRL0 = 8'h04;
  localparam logic [7:0] OFS_CTRL1 = 8'h08;
  localparam logic [7:0] OFS_CTRL2 = 8'h0c;
  localparam logic [7:0] OFS_CTRL3 = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Field positions in the operation register.
  localparam int OP_MASTER_ENABLE = 0;
  localparam int OP_NMI_FLAG = 1;
  localparam int OP_ADDR_ERR_FLAG = 2;
  localparam int OP_DTR_MODE = 3;
  localparam int OP_BURST_PRIO = 4;
  localparam int OP_PRIO_LO = 8;
  localparam int OP_PRIO_HI = 9;

  // Field positions in each channel control register.
  localparam int CC_CHANNEL_ENABLE = 0;
  localparam int CC_TRANSFER_END = 1;
  localparam int CC_BUS_MODE = 2;
  localparam int CC_SENSE = 3;
  localparam int CC_EXT_REQ = 4;
  localparam int CC_DUAL_ADDR = 5;

  // Reset values of the registers.
  localparam logic [9:0] OP_RESET = 10'h000;
  localparam logic [5:0] CC_RESET = 6'h00;

  // Round robin order after reset: channel 0 highest, channel 3 lowest.
  localparam logic [7:0] RR_ORDER_RESET = 8'he4;

  // Unmapped reads return this value.
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // Priority selection encodings.
  typedef enum logic [1:0] {
    DCAB_PRIO_FIX0123 = 2'h0,
    DCAB_PRIO_FIX0231 = 2'h1,
    DCAB_PRIO_FIX2013 = 2'h2,
    DCAB_PRIO_RROBIN = 2'h3
  } dcab_prio_t;

  // Per channel control settings.
  typedef struct packed {
    logic dual_addr;
    logic ext_req;
    logic sense_edge;
    logic burst;
    logic transfer_end;
    logic enable;
  } dcab_chctl_t;

  // One transfer cycle request to the bus state controller.
  typedef struct packed {
    logic [1:0] channel;
    logic write_phase;
    logic dual_addr;
  } dcab_cycle_t;

endpackage

// File: dcab_arbiter.sv
// Priority encoder that picks one requesting channel from a priority order.
module dcab_arbiter
  import dcab_pkg::*;
#(
  parameter int CH = 4
) (
  input wire logic [CH-1:0] request,
  input wire logic [7:0] order,
  output logic valid,
  output logic [1:0] winner
);

  // Scan the order from lowest (slot 3) to highest (slot 0); the last requester found wins.
  always_comb begin
    valid = 1'b0;
    winner = 2'h0;
    for (int s = CH - 1; s >= 0; s--) begin
      if (request[order[2*s +: 2]]) begin
        valid = 1'b1;
        winner = order[2*s +: 2];
      end
    end
  end

endmodule

// File: dcab_props.sv
// Port-level checker for the DMA channel arbiter.
module dcab_props
  import dcab_pkg::*;
#(
  parameter int CH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic unit_done,
  input wire logic bus_request,
  input wire logic cycle_valid,
  input wire dcab_cycle_t cycle_info,
  input wire logic [CH-1:0] transfer_acknowledge_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // The read cycle of a dual address unit has just been finished.
  sequence read_done;
    cycle_valid && unit_done && cycle_info.dual_addr && !cycle_info.write_phase;
  endsequence
  // The final bus cycle of a unit has just been finished.
  sequence last_done;
    cycle_valid && unit_done && (cycle_info.write_phase || !cycle_info.dual_addr);
  endsequence
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer missing");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  unmapped_err_a: assert property (pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  ack_cycle_a: assert property (|transfer_acknowledge_strobe |-> cycle_valid &&
    transfer_acknowledge_strobe == (4'h1 << cycle_info.channel)) else $error("strobe without cycle");
  ack_pulse_a: assert property (|transfer_acknowledge_strobe && unit_done |=>
    transfer_acknowledge_strobe == 4'h0) else $error("strobe too long");
  ack_hold_a: assert property (|transfer_acknowledge_strobe && !unit_done |=>
    $stable(transfer_acknowledge_strobe)) else $error("strobe dropped early");
  dual_write_a: assert property (read_done |=> cycle_valid && cycle_info.write_phase &&
    cycle_info.channel == $past(cycle_info.channel)) else $error("write cycle missing");
  start_read_a: assert property ($rose(cycle_valid) |-> !cycle_info.write_phase)
    else $error("unit began with write");
  unit_gap_a: assert property (last_done |=> !cycle_valid)
    else $error("no gap after unit");
  cycle_hold_a: assert property (cycle_valid && !unit_done |=> cycle_valid && $stable(cycle_info))
    else $error("cycle dropped early");
  bus_own_a: assert property (cycle_valid |-> bus_request)
    else $error("cycle without bus");
endmodule

// File: dcab_far_side.sv
// Model of the external requesting devices and the memory bus slave.
module dcab_far_side
  import dcab_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cycle_valid,
  input wire logic [3:0] want,
  output logic [3:0] req_n,
  output logic unit_done
);
  logic [1:0] wait_ff; // Wait states left in the current cycle.
  // low level request
  // The pins idle high, as req_n is the inverse of want and want is clear outside requests.
  assign req_n = ~want;
  // plain memory
  // Every cycle is answered after a random zero to three wait states.
  always_ff @(posedge clk) begin
    if (!reset_n || unit_done || !cycle_valid) begin
      unit_done <= 1'h0;
      wait_ff <= 2'($urandom_range(3));
    end else if (wait_ff == 2'h0) begin
      unit_done <= 1'h1;
    end else begin
      wait_ff <= wait_ff - 2'h1;
    end
  end
endmodule

// File: tb.sv
// Self-checking testbench for the DMA channel arbiter.
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb
  import dcab_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FIX [3] = '{8'he4, 8'h78, 8'hd2}; // Fixed orders, slot 0 first.
  logic clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h0, ord;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [32:0] q; // Slave error and read data of the last transfer.
  logic pready, pslverr, bus_request, cycle_valid, unit_done;
  logic [3:0] ireq = 4'h0, want = 4'h0, req_n, ack;
  logic ebr = 1'h0, rfr = 1'h0, cv_d = 1'h0; // Outside bus and refresh requests; last busy level.
  dcab_cycle_t info;
  int num_errors = 0, n_tests = 0, nv = 0, nu = 0;
  dcab_top uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_transfer_request_n(req_n), .internal_request(ireq), .unit_done(unit_done),
    .external_bus_request(ebr), .refresh_request(rfr), .bus_request(bus_request),
    .cycle_valid(cycle_valid), .cycle_info(info), .transfer_acknowledge_strobe(ack));
  dcab_far_side far (.clk(clk), .reset_n(reset_n), .cycle_valid(cycle_valid), .want(want),
    .req_n(req_n), .unit_done(unit_done));
  initial forever #12.5 clk = ~clk;
  // Counts busy cycles so that a refused request is seen even if brief, and units by their first cycle.
  always @(posedge clk) begin
    if (cycle_valid === 1'h1) nv++;
    if (cycle_valid === 1'h1 && cv_d !== 1'h1) nu++;
    cv_d <= cycle_valid;
  end
  // One APB transfer; it holds the request until pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'h1 && n < 20);
    if (n >= 20) num_errors++;
    q = {pslverr, prdata};
    psel <= 1'h0; penable <= 1'h0;
  endtask
  // Waits through the gap for the next unit; the gap shows whether the bus was kept.
  task grant(output logic [1:0] ch, output logic br);
    int n;
    n = 0;
    while (cycle_valid === 1'h1 && n < 99) begin @(posedge clk); n++; end
    br = bus_request;
    while (cycle_valid !== 1'h1 && n < 99) begin @(posedge clk); n++; end
    if (n >= 99) num_errors++;
    ch = info.channel;
  endtask
  // Highest priority requester of mask m under order o.
  function logic [1:0] pick(input logic [7:0] o, input logic [3:0] m);
    pick = o[1:0];
    for (int i = 3; i >= 0; i--) if (m[o[2*i+:2]]) pick = o[2*i+:2];
  endfunction
  // Order o with channel c moved to the lowest place.
  function logic [7:0] demote(input logic [7:0] o, input logic [1:0] c);
    logic [7:0] r;
    int k;
    k = 0;
    r = 8'h0;
    for (int i = 0; i < 4; i++) if (o[2*i+:2] != c) begin r[2*k+:2] = o[2*i+:2]; k++; end
    r[7:6] = c;
    return r;
  endfunction
  task conclude;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Whole run needs some 1000 cycles; thirty times that means a hang.
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    conclude();
  end
  initial begin
    logic [1:0] ch;
    logic br, bm;
    logic [3:0] m;
    int v, u;
    void'($urandom(84263));
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    apb(1'h0, OFS_OPERATION, 32'h0); `CHK("op reset", 33'h0, q)
    apb(1'h0, OFS_STATUS, 32'h0); `CHK("rr reset", RR_ORDER_RESET, q[15:8])
    apb(1'h0, 8'h40, 32'h0); `CHK("unmapped", 33'h1_0000_0000, q)
    for (int i = 0; i < 4; i++) apb(1'h1, OFS_CTRL0 + 8'(4*i), 32'h21);
    // Channels are armed but the master enable is still clear.
    v = nv;
    ireq <= 4'hf;
    repeat (12) @(posedge clk);
    `CHK("no master", v, nv)
    ireq <= 4'h0;
    for (int c = 0; c < 4; c++) begin
      bm = 1'($urandom_range(1));
      for (int i = 0; i < 4; i++) apb(1'h1, OFS_CTRL0 + 8'(4*i), {29'h0, bm, 2'h1} | 32'h20);
      apb(1'h1, OFS_OPERATION, {22'h0, 2'(c), 8'h01});
      apb(1'h0, OFS_OPERATION, 32'h0); `CHK("op rw", {23'h0, 2'(c), 8'h01}, q)
      m = (c == 0) ? 4'hf : 4'($urandom_range(14)) + 4'h1;
      ord = (c == 3) ? RR_ORDER_RESET : FIX[c];
      ireq <= m;
      for (int k = 0; k < 6; k++) begin
        grant(ch, br);
        `CHK("grant", pick(ord, m), ch)
        if (k > 0) `CHK("bus kept", bm, br)
        if (c == 3) ord = demote(ord, ch);
      end
      ireq <= 4'h0;
      repeat (20) @(posedge clk);
      apb(1'h0, OFS_STATUS, 32'h0); `CHK("rr idle", RR_ORDER_RESET, q[15:8])
    end
    // A finished channel is skipped even though it still asks.
    apb(1'h1, OFS_CTRL0, 32'h23);
    apb(1'h1, OFS_OPERATION, 32'h01);
    ireq <= 4'h3;
    grant(ch, br); `CHK("te skip", 2'h1, ch)
    ireq <= 4'h0;
    repeat (20) @(posedge clk);
    // Pin request on channel 2 and internal request on a single address channel.
    apb(1'h1, OFS_CTRL1, 32'h01);
    apb(1'h1, OFS_CTRL2, 32'h11);
    v = nv;
    ireq <= 4'h2;
    want <= 4'h4;
    repeat (20) @(posedge clk);
    `CHK("refused", v, nv)
    apb(1'h1, OFS_OPERATION, 32'h09);
    grant(ch, br); `CHK("pin grant", 2'h2, ch)
    `CHK("strobe", 4'h4, ack)
    `CHK("single", 1'h0, info.dual_addr)
    want <= 4'h0;
    ireq <= 4'h0;
    repeat (20) @(posedge clk);
    // A falling edge on the pin buys exactly one unit; a held low level keeps asking.
    apb(1'h1, OFS_OPERATION, 32'h01);
    apb(1'h1, OFS_CTRL0, 32'h19);
    u = nu;
    want <= 4'h1;
    repeat (40) @(posedge clk);
    `CHK("edge once", u + 1, nu)
    apb(1'h1, OFS_CTRL0, 32'h15);
    u = nu;
    repeat (40) @(posedge clk);
    `CHK("level runs", 1'h1, 1'(nu > u + 2))
    // Level burst keeps the bus unless an outside request may break in.
    grant(ch, br);
    grant(ch, br); `CHK("burst kept", 1'h1, br)
    ebr <= 1'h1;
    grant(ch, br);
    grant(ch, br); `CHK("bus req breaks", 1'h0, br)
    ebr <= 1'h0;
    rfr <= 1'h1;
    grant(ch, br);
    grant(ch, br); `CHK("refresh breaks", 1'h0, br)
    apb(1'h1, OFS_OPERATION, 32'h11);
    grant(ch, br);
    grant(ch, br); `CHK("burst priority", 1'h1, br)
    rfr <= 1'h0;
    want <= 4'h0;
    repeat (20) @(posedge clk);
    `CHK("level stop", 2'h0, {bus_request, cycle_valid})
    // A higher channel takes over a burst at the next unit and holds it while it asks.
    apb(1'h1, OFS_OPERATION, 32'h01);
    apb(1'h1, OFS_CTRL0, 32'h21);
    apb(1'h1, OFS_CTRL1, 32'h25);
    ireq <= 4'h2;
    grant(ch, br); `CHK("burst start", 2'h1, ch)
    ireq <= 4'h3;
    grant(ch, br); `CHK("preempt", 2'h0, ch)
    grant(ch, br); `CHK("fixed hold", 2'h0, ch)
    ireq <= 4'h2;
    grant(ch, br); `CHK("resume", 2'h1, ch)
    ireq <= 4'h0;
    repeat (20) @(posedge clk);
    // Round robin lets the preempted burst channel alternate unit by unit.
    apb(1'h1, OFS_OPERATION, 32'h301);
    ireq <= 4'h3;
    for (int k = 0; k < 4; k++) begin
      grant(ch, br); `CHK("alternate", 2'(k % 2), ch)
    end
    ireq <= 4'h0;
    repeat (20) @(posedge clk);
    conclude();
  end
endmodule
bind dcab_top dcab_props #(.CH(CH)) chk (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .unit_done(unit_done),
  .bus_request(bus_request), .cycle_valid(cycle_valid), .cycle_info(cycle_info),
  .transfer_acknowledge_strobe(transfer_acknowledge_strobe));
